// ### core/hsw_defines.svh
// Purpose: shared constants of the host serial port and report link
// Assumes: 20 MHz system clock
// Notes:   counts derive from the times beside them
`ifndef HSW_DEFINES_SVH
`define HSW_DEFINES_SVH

// ==========================================================
// timing
`define HSW_CLK_MHZ      20
`define HSW_REPORT_US    10000
`define HSW_BAUD         115200
`define HSW_BIT_CYCLES   ((`HSW_CLK_MHZ * 1000000) / `HSW_BAUD)
`define HSW_SCLK_HALF    8
`define HSW_STRAP_WAIT   2'h3

// ==========================================================
// report layout
`define HSW_RPT_HEADER   8'hAA
`define HSW_RPT_LAST     5'h12
`define HSW_RPT_SUM_LO   5'h02
`define HSW_RPT_WORD_LO  5'h03
`define HSW_RPT_WORD_HI  5'h0E

// ==========================================================
// synchroniser slots of the device pins
`define HSW_PIN_SCLK     0
`define HSW_PIN_CS       1
`define HSW_PIN_MOSI     2
`define HSW_PIN_WAKE     3
`define HSW_PIN_PHI      4
`define HSW_PIN_BOOT     5
`define HSW_PIN_COUNT    6

`endif

// ### core/hsw_device.sv
// Purpose: device end: serial slave port with wake/attention, and report UART
// Assumes: link pins are asynchronous to clk_sys_in and pass two flip-flops
// Notes:   straps are caught a few cycles after reset release
// Operation
// - host holds both straps high for serial mode
// - upper low, lower high selects report UART
// - low boot select at reset enters boot-loader
// - attention output is active low
// - clock idles high, capture on rising edge
// - bytes of eight bits, MSB first
// - any number of bytes per select
// - host clocks, device shifts both ways
// - lower strap becomes wake input after reset
// - host pulls wake low, awaits attention
// - wake low leaves sleep, raises attention
// - chip select releases attention at once
// - one report every 10 ms
// - UART idle high, 8N1, LSB first
// - 19-byte report in fixed field order
// - index counts up per report, wraps
// - angles signed, 0.01 degree steps
// - accelerations signed, in milli-g
// - three reserved bytes sent as zero
// - checksum sums all bytes but header
`timescale 1ns/1ps
`include "hsw_defines.svh"
module hsw_device #(
	parameter int REPORT_CYCLES = `HSW_REPORT_US * `HSW_CLK_MHZ
) (
	// system
	input  wire logic              clk_sys_in,
	input  wire logic              arst_n_in,
	input  wire logic              ce_in,
	// link pins
	hsw_link_if.device             link,
	// serial port data
	input  wire logic [7:0]        spi_tx_data_in,
	output logic                   spi_tx_taken_out,
	output logic [7:0]             spi_rx_data_out,
	output logic                   spi_rx_valid_out,
	// service and power
	input  wire logic              need_service_in,
	input  wire logic              sleep_req_in,
	// report values: yaw, pitch, roll, accel x, y, z
	input  wire hsw_pkg::hsw_words_t report_words_in,
	// mode status
	output logic                   spi_mode_out,
	output logic                   report_mode_out,
	output logic                   bootloader_out,
	output logic                   asleep_out
);

	// ==========================================================
	// pin synchronisers
	logic [`HSW_PIN_COUNT-1:0] pin_raw;
	logic [`HSW_PIN_COUNT-1:0] pin_s1;
	logic [`HSW_PIN_COUNT-1:0] pin_s2;
	logic [`HSW_PIN_COUNT-1:0] pin_s3;

	assign pin_raw = {link.boot_select_n, link.proto_select_hi, link.proto_select_lo_wake_n,
		link.mosi, link.cs_n, link.sclk};

	genvar gi;
	generate
		for (gi = 0; gi < `HSW_PIN_COUNT; gi++) begin : g_sync
			always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					pin_s1[gi] <= 1'b1;
					pin_s2[gi] <= 1'b1;
					pin_s3[gi] <= 1'b1;
				end else if (ce_in) begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
				end
			end
		end
	endgenerate

	wire sclk_rise = pin_s2[`HSW_PIN_SCLK] & ~pin_s3[`HSW_PIN_SCLK];
	wire sclk_fall = ~pin_s2[`HSW_PIN_SCLK] & pin_s3[`HSW_PIN_SCLK];
	wire cs_active = ~pin_s2[`HSW_PIN_CS];
	wire cs_fall   = ~pin_s2[`HSW_PIN_CS] & pin_s3[`HSW_PIN_CS];
	wire wake_fall = ~pin_s2[`HSW_PIN_WAKE] & pin_s3[`HSW_PIN_WAKE];
	wire mosi_bit  = pin_s2[`HSW_PIN_MOSI];

	// ==========================================================
	// strap capture after reset release
	logic [1:0] strap_cnt;
	logic       strap_done;
	logic       first_attn;
	wire        strap_take = ~strap_done & (strap_cnt == `HSW_STRAP_WAIT);
	wire        strap_hi   = pin_s2[`HSW_PIN_PHI];
	wire        strap_lo   = pin_s2[`HSW_PIN_WAKE];

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strap_cnt       <= 2'h0;
			strap_done      <= 1'b0;
			first_attn      <= 1'b0;
			spi_mode_out    <= 1'b0;
			report_mode_out <= 1'b0;
			bootloader_out  <= 1'b0;
		end else if (ce_in) begin
			first_attn <= strap_take & strap_hi & strap_lo;
			if (!strap_done) begin
				strap_cnt <= strap_cnt + 2'h1;
			end
			if (strap_take) begin
				strap_done      <= 1'b1;
				spi_mode_out    <= strap_hi & strap_lo;
				report_mode_out <= ~strap_hi & strap_lo;
				bootloader_out  <= ~pin_s2[`HSW_PIN_BOOT];
			end
		end
	end

	// ==========================================================
	// attention and sleep
	logic need_prev;
	logic attn_n;
	wire  wake_ev = spi_mode_out & wake_fall;
	wire  attn_set = first_attn | wake_ev | (spi_mode_out & need_service_in & ~need_prev);
	wire  attn_clr = spi_mode_out & cs_fall;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			need_prev  <= 1'b0;
			attn_n     <= 1'b1;
			asleep_out <= 1'b0;
		end else if (ce_in) begin
			need_prev <= need_service_in;
			if (attn_set) begin
				attn_n <= 1'b0;
			end else if (attn_clr) begin
				attn_n <= 1'b1;
			end
			if (wake_ev) begin
				asleep_out <= 1'b0;
			end else if (sleep_req_in & spi_mode_out) begin
				asleep_out <= 1'b1;
			end
		end
	end

	assign link.host_attention_irq_n = attn_n;

	// ==========================================================
	// serial slave shifter
	logic [2:0] bit_cnt;
	logic [7:0] rx_sh;
	logic [7:0] tx_sh;
	logic       miso_q;
	wire        spi_on    = spi_mode_out & cs_active;
	wire        byte_load = spi_on & sclk_fall & (bit_cnt == 3'h0);

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bit_cnt          <= 3'h0;
			rx_sh            <= 8'h00;
			tx_sh            <= 8'h00;
			miso_q           <= 1'b1;
			spi_rx_data_out  <= 8'h00;
			spi_rx_valid_out <= 1'b0;
			spi_tx_taken_out <= 1'b0;
		end else if (ce_in) begin
			spi_rx_valid_out <= 1'b0;
			spi_tx_taken_out <= byte_load;
			if (!spi_on) begin
				bit_cnt <= 3'h0;
			end else if (sclk_rise) begin
				rx_sh   <= {rx_sh[6:0], mosi_bit};
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					spi_rx_data_out  <= {rx_sh[6:0], mosi_bit};
					spi_rx_valid_out <= 1'b1;
				end
			end
			if (byte_load) begin
				miso_q <= spi_tx_data_in[7];
				tx_sh  <= {spi_tx_data_in[6:0], 1'b0};
			end else if (spi_on & sclk_fall) begin
				miso_q <= tx_sh[7];
				tx_sh  <= {tx_sh[6:0], 1'b0};
			end
		end
	end

	assign link.miso = miso_q;

	// ==========================================================
	// report assembly
	function automatic logic [7:0] rpt_byte(
		input logic [4:0]          idx,
		input hsw_pkg::hsw_words_t w,
		input logic [7:0]          seq,
		input logic [7:0]          sum
	);
		logic [4:0] off;
		off = idx - `HSW_RPT_WORD_LO;
		if (idx < `HSW_RPT_SUM_LO) begin
			rpt_byte = `HSW_RPT_HEADER;
		end else if (idx == `HSW_RPT_SUM_LO) begin
			rpt_byte = seq;
		end else if (idx <= `HSW_RPT_WORD_HI) begin
			rpt_byte = off[0] ? w[off[3:1]][15:8] : w[off[3:1]][7:0];
		end else if (idx < `HSW_RPT_LAST) begin
			rpt_byte = 8'h00;
		end else begin
			rpt_byte = sum;
		end
	endfunction

	logic [31:0]         rpt_timer;
	logic                rpt_busy;
	logic [4:0]          byte_idx;
	logic [7:0]          seq_idx;
	logic [7:0]          csum;
	hsw_pkg::hsw_words_t snap;
	hsw_pkg::hsw_uart_e  ut_state;
	logic [15:0]         baud_cnt;
	logic [2:0]          ut_bit;
	logic [7:0]          ut_sh;
	logic                tx_q;

	wire       rpt_due   = rpt_timer == 32'(REPORT_CYCLES - 1);
	wire       rpt_on    = report_mode_out & ~bootloader_out;
	wire       byte_next = rpt_busy & (ut_state == hsw_pkg::HSW_U_IDLE);
	wire [7:0] cur_byte  = rpt_byte(byte_idx, snap, seq_idx, csum);
	wire       in_sum    = (byte_idx >= `HSW_RPT_SUM_LO) & (byte_idx < `HSW_RPT_LAST);
	wire       bit_end   = baud_cnt == 16'(`HSW_BIT_CYCLES - 1);

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rpt_timer <= 32'h0;
			rpt_busy  <= 1'b0;
			byte_idx  <= 5'h00;
			seq_idx   <= 8'h00;
			csum      <= 8'h00;
			snap      <= '0;
		end else if (ce_in) begin
			rpt_timer <= (rpt_due | ~rpt_on) ? 32'h0 : rpt_timer + 32'h1;
			if (rpt_on & rpt_due & ~rpt_busy) begin
				rpt_busy <= 1'b1;
				byte_idx <= 5'h00;
				csum     <= 8'h00;
				snap     <= report_words_in;
			end else if (byte_next) begin
				csum     <= in_sum ? csum + cur_byte : csum;
				byte_idx <= byte_idx + 5'h01;
				if (byte_idx == `HSW_RPT_LAST) begin
					rpt_busy <= 1'b0;
					seq_idx  <= seq_idx + 8'h01;
				end
			end
		end
	end

	// ==========================================================
	// UART transmitter
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ut_state <= hsw_pkg::HSW_U_IDLE;
			baud_cnt <= 16'h0000;
			ut_bit   <= 3'h0;
			ut_sh    <= 8'h00;
			tx_q     <= 1'b1;
		end else if (ce_in) begin
			baud_cnt <= bit_end ? 16'h0000 : baud_cnt + 16'h0001;
			case (ut_state)
				hsw_pkg::HSW_U_IDLE: begin
					tx_q     <= 1'b1;
					baud_cnt <= 16'h0000;
					if (byte_next) begin
						ut_sh    <= cur_byte;
						tx_q     <= 1'b0;
						ut_state <= hsw_pkg::HSW_U_START;
					end
				end
				hsw_pkg::HSW_U_START: begin
					if (bit_end) begin
						tx_q     <= ut_sh[0];
						ut_sh    <= {1'b0, ut_sh[7:1]};
						ut_bit   <= 3'h0;
						ut_state <= hsw_pkg::HSW_U_DATA;
					end
				end
				hsw_pkg::HSW_U_DATA: begin
					if (bit_end) begin
						ut_bit <= ut_bit + 3'h1;
						tx_q   <= (ut_bit == 3'h7) ? 1'b1 : ut_sh[0];
						ut_sh  <= {1'b0, ut_sh[7:1]};
						if (ut_bit == 3'h7) begin
							ut_state <= hsw_pkg::HSW_U_STOP;
						end
					end
				end
				hsw_pkg::HSW_U_STOP: begin
					if (bit_end) begin
						ut_state <= hsw_pkg::HSW_U_IDLE;
					end
				end
				default: begin
					ut_state <= hsw_pkg::HSW_U_IDLE;
				end
			endcase
		end
	end

	assign link.uart_tx = tx_q;

endmodule

// ### core/hsw_host.sv
// Purpose: host end: straps, wake request and serial port master
// Assumes: serial clock made here from clk_sys_in by a divider
// Notes:   one byte offered at a time; last marks the end of a select
`timescale 1ns/1ps
`include "hsw_defines.svh"
module hsw_host (
	// system
	input  wire logic       clk_sys_in,
	input  wire logic       arst_n_in,
	input  wire logic       ce_in,
	// link pins
	hsw_link_if.host        link,
	// strap choices
	input  wire logic       report_mode_sel_in,
	input  wire logic       boot_loader_req_in,
	// byte requests
	input  wire logic       xfer_valid_in,
	input  wire logic [7:0] xfer_data_in,
	input  wire logic       xfer_last_in,
	output logic            xfer_taken_out,
	// received bytes
	output logic [7:0]      rx_data_out,
	output logic            rx_valid_out,
	output logic            busy_out
);

	// ==========================================================
	// input synchronisers
	logic [1:0] in_s1;
	logic [1:0] in_s2;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			in_s1 <= 2'h3;
			in_s2 <= 2'h3;
		end else if (ce_in) begin
			in_s1 <= {link.host_attention_irq_n, link.miso};
			in_s2 <= in_s1;
		end
	end

	wire attn_low = ~in_s2[1];
	wire miso_bit = in_s2[0];

	// ==========================================================
	// master sequencer
	hsw_pkg::hsw_host_e state;
	logic [3:0]         half_cnt;
	logic [2:0]         bits;
	logic [7:0]         tx_sh;
	logic [7:0]         rx_sh;
	logic               last_q;
	logic               sclk_q;
	logic               cs_n_q;
	logic               mosi_q;
	logic               wake_n_q;
	logic               phi_q;
	logic               boot_n_q;

	wire half_done = half_cnt == 4'(`HSW_SCLK_HALF - 1);
	wire in_high   = state == hsw_pkg::HSW_H_HIGH;
	wire load_next = half_done & in_high & (bits == 3'h0) & ~last_q & xfer_valid_in;
	wire do_fall   = half_done & ((state == hsw_pkg::HSW_H_LEAD) | (in_high & (bits != 3'h0)));
	wire start_ok  = (state == hsw_pkg::HSW_H_IDLE) & xfer_valid_in;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state          <= hsw_pkg::HSW_H_IDLE;
			half_cnt       <= 4'h0;
			bits           <= 3'h0;
			tx_sh          <= 8'h00;
			rx_sh          <= 8'h00;
			last_q         <= 1'b0;
			sclk_q         <= 1'b1;
			cs_n_q         <= 1'b1;
			mosi_q         <= 1'b1;
			wake_n_q       <= 1'b1;
			phi_q          <= 1'b1;
			boot_n_q       <= 1'b1;
			xfer_taken_out <= 1'b0;
			rx_data_out    <= 8'h00;
			rx_valid_out   <= 1'b0;
			busy_out       <= 1'b0;
		end else if (ce_in) begin
			phi_q          <= ~report_mode_sel_in;
			boot_n_q       <= ~boot_loader_req_in;
			xfer_taken_out <= start_ok | load_next;
			rx_valid_out   <= 1'b0;
			busy_out       <= (state != hsw_pkg::HSW_H_IDLE) | xfer_valid_in;
			half_cnt       <= half_done ? 4'h0 : half_cnt + 4'h1;
			if (start_ok) begin
				tx_sh  <= xfer_data_in;
				last_q <= xfer_last_in;
			end
			if (load_next) begin
				sclk_q <= 1'b0;
				mosi_q <= xfer_data_in[7];
				tx_sh  <= {xfer_data_in[6:0], 1'b0};
				last_q <= xfer_last_in;
			end else if (do_fall) begin
				sclk_q <= 1'b0;
				mosi_q <= tx_sh[7];
				tx_sh  <= {tx_sh[6:0], 1'b0};
			end
			case (state)
				hsw_pkg::HSW_H_IDLE: begin
					half_cnt <= 4'h0;
					if (start_ok & attn_low) begin
						cs_n_q <= 1'b0;
						state  <= hsw_pkg::HSW_H_LEAD;
					end else if (start_ok) begin
						wake_n_q <= 1'b0;
						state    <= hsw_pkg::HSW_H_WAKE;
					end
				end
				hsw_pkg::HSW_H_WAKE: begin
					half_cnt <= 4'h0;
					if (attn_low) begin
						wake_n_q <= 1'b1;
						cs_n_q   <= 1'b0;
						state    <= hsw_pkg::HSW_H_LEAD;
					end
				end
				hsw_pkg::HSW_H_LEAD: begin
					if (half_done) begin
						state <= hsw_pkg::HSW_H_LOW;
					end
				end
				hsw_pkg::HSW_H_LOW: begin
					if (half_done) begin
						sclk_q <= 1'b1;
						rx_sh  <= {rx_sh[6:0], miso_bit};
						bits   <= bits + 3'h1;
						state  <= hsw_pkg::HSW_H_HIGH;
						if (bits == 3'h7) begin
							rx_data_out  <= {rx_sh[6:0], miso_bit};
							rx_valid_out <= 1'b1;
						end
					end
				end
				hsw_pkg::HSW_H_HIGH: begin
					if (load_next | do_fall) begin
						state <= hsw_pkg::HSW_H_LOW;
					end else if (half_done & (bits == 3'h0) & last_q) begin
						state <= hsw_pkg::HSW_H_TAIL;
					end else if (half_done & (bits == 3'h0)) begin
						half_cnt <= half_cnt;
					end
				end
				hsw_pkg::HSW_H_TAIL: begin
					if (half_done) begin
						cs_n_q <= 1'b1;
						mosi_q <= 1'b1;
						state  <= hsw_pkg::HSW_H_GAP;
					end
				end
				hsw_pkg::HSW_H_GAP: begin
					if (half_done) begin
						state <= hsw_pkg::HSW_H_IDLE;
					end
				end
				default: begin
					state <= hsw_pkg::HSW_H_IDLE;
				end
			endcase
		end
	end

	assign link.sclk                   = sclk_q;
	assign link.cs_n                   = cs_n_q;
	assign link.mosi                   = mosi_q;
	assign link.proto_select_lo_wake_n = wake_n_q;
	assign link.proto_select_hi        = phi_q;
	assign link.boot_select_n          = boot_n_q;

endmodule

// ### core/hsw_link_if.sv
// Purpose: pins between the host and the device
// Assumes: every pin is one-way
// Notes:   no clocking block; the bench joins both ends here
`timescale 1ns/1ps
interface hsw_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic host_attention_irq_n;
	logic proto_select_hi;
	logic proto_select_lo_wake_n;
	logic boot_select_n;
	logic uart_tx;

	modport device (
		input  sclk, cs_n, mosi, proto_select_hi, proto_select_lo_wake_n, boot_select_n,
		output miso, host_attention_irq_n, uart_tx
	);
	modport host (
		output sclk, cs_n, mosi, proto_select_hi, proto_select_lo_wake_n, boot_select_n,
		input  miso, host_attention_irq_n, uart_tx
	);
endinterface

// ### core/hsw_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes:   constants live in hsw_defines.svh
package hsw_pkg;
	typedef logic [5:0][15:0] hsw_words_t;
	typedef enum logic [3:0] {
		HSW_U_IDLE  = 4'h1,
		HSW_U_START = 4'h2,
		HSW_U_DATA  = 4'h4,
		HSW_U_STOP  = 4'h8
	} hsw_uart_e;
	typedef enum logic [6:0] {
		HSW_H_IDLE = 7'h01,
		HSW_H_WAKE = 7'h02,
		HSW_H_LEAD = 7'h04,
		HSW_H_LOW  = 7'h08,
		HSW_H_HIGH = 7'h10,
		HSW_H_TAIL = 7'h20,
		HSW_H_GAP  = 7'h40
	} hsw_host_e;
endpackage

// ### tb/hsw_assertions.sv
// Purpose: link checks between the host and device ends
// Assumes: 20 MHz clock, 173-cycle report bit
// Notes:   takes the interface signals as plain inputs
`timescale 1ns/1ps
module hsw_assertions (
	// system
	input  wire logic clk_sys_in,
	input  wire logic arst_n_in,
	// link
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic mosi,
	input  wire logic miso,
	input  wire logic host_attention_irq_n,
	input  wire logic proto_select_lo_wake_n,
	input  wire logic uart_tx
);
	localparam int UART_BIT = 173;
	localparam int STOP_AT  = 9 * UART_BIT;
	localparam int FRAME    = 10 * UART_BIT - 1;
	logic [10:0] fcnt;
	logic        fbusy;
	logic [2:0]  bits;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!arst_n_in);

	// ==========================================================
	// helpers: frame position of the report line, bits per select
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fbusy <= 1'b0;
			fcnt  <= 11'h000;
		end else if (!fbusy && $fell(uart_tx)) begin
			fbusy <= 1'b1;
			fcnt  <= 11'h001;
		end else if (fbusy) begin
			fbusy <= (fcnt != 11'(FRAME));
			fcnt  <= fcnt + 11'h001;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bits <= 3'h0;
		end else if (cs_n) begin
			bits <= 3'h0;
		end else if ($rose(sclk)) begin
			bits <= bits + 3'h1;
		end
	end

	sequence s_attn_low;
		##[1:8] !host_attention_irq_n;
	endsequence
	sequence s_attn_high;
		##[1:5] host_attention_irq_n;
	endsequence

	// ==========================================================
	// serial port
	AST_SCLK_IDLE: assert property (cs_n |-> sclk)
		else $error("serial clock low outside select");
	AST_SCLK_LOW: assert property ($fell(sclk) |-> (!sclk) [*8])
		else $error("serial clock low half too short");
	AST_MOSI_HOLD: assert property (!cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(mosi))
		else $error("mosi moved while clock high");
	AST_MISO_FALL: assert property (!cs_n && $changed(miso) |-> !sclk)
		else $error("miso moved while clock high");
	AST_BYTE_WHOLE: assert property ($rose(cs_n) |-> bits == 3'h0)
		else $error("select ended inside a byte");
	AST_ATTN_CLEAR: assert property ($fell(cs_n) |-> s_attn_high)
		else $error("attention kept after select");
	AST_WAKE_ATTN: assert property ($fell(proto_select_lo_wake_n) |-> s_attn_low)
		else $error("no attention after wake");
	AST_CS_AFTER_ATTN: assert property ($fell(cs_n) |-> !$past(host_attention_irq_n))
		else $error("select before attention");

	// ==========================================================
	// report line
	AST_UART_START: assert property (fbusy && fcnt < UART_BIT |-> !uart_tx)
		else $error("start bit not held low");
	AST_UART_STOP: assert property (fbusy && fcnt >= STOP_AT |-> uart_tx)
		else $error("stop bit not high");
endmodule

// ### tb/test_host_spi_wake_and_rvc_uart_tx.sv
// Purpose: both ends joined; serial transfers, wake, modes, report frames
// Assumes: 20 MHz clock, report period shortened to RPT
// Notes:   inputs change at the falling clock edge
`timescale 1ns/1ps
module test_host_spi_wake_and_rvc_uart_tx;
	localparam int RPT  = 33000;
	localparam int BITC = 173;
	logic                clk_sys_in         = 1'b0;
	logic                arst_n_in          = 1'b0;
	logic [7:0]          spi_tx_data_in     = 8'h00;
	logic                need_service_in    = 1'b0;
	logic                sleep_req_in       = 1'b0;
	hsw_pkg::hsw_words_t report_words_in    = '0;
	logic                report_mode_sel_in = 1'b0;
	logic                boot_loader_req_in = 1'b0;
	logic                xfer_valid_in      = 1'b0;
	logic [7:0]          xfer_data_in       = 8'h00;
	logic                xfer_last_in       = 1'b0;
	logic                spi_tx_taken_out, spi_rx_valid_out, spi_mode_out, report_mode_out;
	logic                bootloader_out, asleep_out, xfer_taken_out, rx_valid_out, busy_out;
	logic [7:0]          spi_rx_data_out, rx_data_out, shm, shs, b;
	logic [7:0]          dev_tx[$], dev_rx[$], host_rx[$], wm[$], ws[$];
	int                  err_count   = 0;
	int                  comparisons = 0;
	int                  cyc = 0;
	int                  nb  = 0;
	int                  t0, t1;

	hsw_link_if link ();
	hsw_device #(.REPORT_CYCLES(RPT)) hsw_device_i (
		.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .ce_in(1'b1), .link(link.device),
		.spi_tx_data_in(spi_tx_data_in), .spi_tx_taken_out(spi_tx_taken_out),
		.spi_rx_data_out(spi_rx_data_out), .spi_rx_valid_out(spi_rx_valid_out),
		.need_service_in(need_service_in), .sleep_req_in(sleep_req_in),
		.report_words_in(report_words_in), .spi_mode_out(spi_mode_out),
		.report_mode_out(report_mode_out), .bootloader_out(bootloader_out),
		.asleep_out(asleep_out));
	hsw_host hsw_host_i (
		.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .ce_in(1'b1), .link(link.host),
		.report_mode_sel_in(report_mode_sel_in), .boot_loader_req_in(boot_loader_req_in),
		.xfer_valid_in(xfer_valid_in), .xfer_data_in(xfer_data_in),
		.xfer_last_in(xfer_last_in), .xfer_taken_out(xfer_taken_out),
		.rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out), .busy_out(busy_out));
	hsw_assertions hsw_assertions_i (
		.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .sclk(link.sclk), .cs_n(link.cs_n),
		.mosi(link.mosi), .miso(link.miso), .host_attention_irq_n(link.host_attention_irq_n),
		.proto_select_lo_wake_n(link.proto_select_lo_wake_n), .uart_tx(link.uart_tx));

	// ==========================================================
	// clock, monitors and next slave byte
	always #25 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) cyc++;
	always @(negedge clk_sys_in) begin
		if (spi_rx_valid_out === 1'b1) dev_rx.push_back(spi_rx_data_out);
		if (rx_valid_out === 1'b1) host_rx.push_back(rx_data_out);
		if (spi_tx_taken_out === 1'b1 && dev_tx.size() > 1) begin
			void'(dev_tx.pop_front());
			spi_tx_data_in <= dev_tx[0];
		end
	end
	always @(posedge link.sclk) begin
		if (link.cs_n === 1'b0) begin
			shm = {shm[6:0], link.mosi};
			shs = {shs[6:0], link.miso};
			nb++;
			if (nb % 8 == 0) begin
				wm.push_back(shm);
				ws.push_back(shs);
			end
		end
	end
	always @(posedge link.cs_n) nb = 0;

	// ==========================================================
	// checks, expectations and bus tasks
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask
	function automatic logic [7:0] rpt_byte(input hsw_pkg::hsw_words_t wd, input logic [7:0] idx,
		input int k);
		logic [7:0] s;
		s = 8'h00;
		if (k < 2) return 8'hAA;
		if (k == 2) return idx;
		if (k < 15) return wd[(k - 3) / 2][((k - 3) % 2) * 8 +: 8];
		if (k < 18) return 8'h00;
		for (int j = 2; j < 18; j++) s = s + rpt_byte(wd, idx, j);
		return s;
	endfunction
	task automatic do_reset(input logic sel, input logic boot);
		arst_n_in = 1'b0;
		report_mode_sel_in = sel;
		boot_loader_req_in = boot;
		repeat (10) @(negedge clk_sys_in);
		arst_n_in = 1'b1;
		repeat (20) @(negedge clk_sys_in);
		check_bit(bootloader_out, boot, "boot loader");
		if (!boot) begin
			check_bit(spi_mode_out, !sel, "serial mode");
			check_bit(report_mode_out, sel, "report mode");
		end
	endtask
	task automatic xfer(input int n, input logic [7:0] first);
		logic [7:0] hb[$];
		logic [7:0] db[$];
		int w;
		dev_rx.delete();
		host_rx.delete();
		wm.delete();
		ws.delete();
		for (int i = 0; i < n; i++) begin
			hb.push_back(i == 0 ? first : 8'($urandom));
			db.push_back(i == 0 ? ~first : 8'($urandom));
		end
		dev_tx = db;
		spi_tx_data_in = db[0];
		for (int i = 0; i < n; i++) begin
			xfer_valid_in = 1'b1;
			xfer_data_in = hb[i];
			xfer_last_in = (i == n - 1);
			w = 0;
			do begin
				@(negedge clk_sys_in);
				w++;
			end while (xfer_taken_out !== 1'b1 && w < 3000);
			check_bit(xfer_taken_out, 1'b1, "byte taken");
		end
		xfer_valid_in = 1'b0;
		for (w = 0; w < 3000 && busy_out !== 1'b0; w++) @(negedge clk_sys_in);
		check_bit(busy_out, 1'b0, "transfer ended");
		check_byte(8'(dev_rx.size()), 8'(n), "byte count");
		for (int i = 0; i < n; i++) begin
			check_byte(dev_rx[i], hb[i], "slave rx");
			check_byte(host_rx[i], db[i], "master rx");
			check_byte(wm[i], hb[i], "mosi wire");
			check_byte(ws[i], db[i], "miso wire");
		end
		check_bit(link.host_attention_irq_n, 1'b1, "attention released");
	endtask
	task automatic uart_byte(output logic [7:0] r);
		int w;
		for (w = 0; w < 40000 && link.uart_tx !== 1'b0; w++) @(negedge clk_sys_in);
		check_bit(link.uart_tx, 1'b0, "start bit");
		repeat (BITC / 2) @(negedge clk_sys_in);
		for (int i = 0; i < 8; i++) begin
			repeat (BITC) @(negedge clk_sys_in);
			r[i] = link.uart_tx;
		end
		repeat (BITC) @(negedge clk_sys_in);
		check_bit(link.uart_tx, 1'b1, "stop bit");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ==========================================================
	// tests
	initial begin
		repeat (90000) @(posedge clk_sys_in);
		err_count++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'h8148));
		@(negedge clk_sys_in);
		do_reset(1'b0, 1'b0);
		check_bit(link.host_attention_irq_n, 1'b0, "first attention");
		xfer(1, 8'h80);
		xfer(6, 8'h01);
		for (int t = 0; t < 4; t++) begin
			if (t % 2 == 1) begin
				sleep_req_in = 1'b1;
				repeat (4) @(negedge clk_sys_in);
				sleep_req_in = 1'b0;
				check_bit(asleep_out, 1'b1, "asleep");
			end else begin
				need_service_in = 1'b1;
				repeat (6) @(negedge clk_sys_in);
				need_service_in = 1'b0;
				check_bit(link.host_attention_irq_n, 1'b0, "service attention");
			end
			xfer(1 + $urandom_range(5), 8'($urandom));
			check_bit(asleep_out, 1'b0, "woken");
		end
		$display("test serial done");
		for (int i = 0; i < 6; i++) report_words_in[i] = 16'($urandom);
		do_reset(1'b1, 1'b0);
		for (int k = 0; k < 19; k++) begin
			uart_byte(b);
			if (k == 0) t0 = cyc;
			check_byte(b, rpt_byte(report_words_in, 8'h00, k), "report byte");
		end
		for (int k = 0; k < 3; k++) begin
			uart_byte(b);
			if (k == 0) t1 = cyc;
			check_byte(b, rpt_byte(report_words_in, 8'h01, k), "next report");
		end
		check_bit(t1 - t0 == RPT, 1'b1, "report period");
		$display("test report done");
		do_reset(1'b0, 1'b1);
		$display("test boot done");
		wrap_up();
	end
endmodule
